// >>> common/lag_pkg.sv
// Purpose: Shared constants for the address generation block.
// Assumes: AHB-Lite register access, 32-bit data, byte offsets.
// Notes: Register offsets and field positions are local choices.
package lag_pkg;
  typedef enum logic [1:0] {LAG_MODE_LEGACY, LAG_MODE_COMPAT, LAG_MODE_64} lag_mode_t;
  typedef enum logic [2:0] {LAG_SEG_EXTRA, LAG_SEG_CODE, LAG_SEG_STACK, LAG_SEG_DATA,
                            LAG_SEG_XF, LAG_SEG_XG} lag_seg_t;
  typedef enum logic [1:0] {LAG_VIEW_DWORD, LAG_VIEW_WORD, LAG_VIEW_LOW, LAG_VIEW_HIGH} lag_view_t;
  typedef enum logic [1:0] {LAG_ASZ_16, LAG_ASZ_32, LAG_ASZ_64} lag_asz_t;
  // Register indices in hardware encoding order
  localparam logic [2:0] LAG_R_ACC = 3'h0;
  localparam logic [2:0] LAG_R_CNT = 3'h1;
  localparam logic [2:0] LAG_R_IO = 3'h2;
  localparam logic [2:0] LAG_R_BASE = 3'h3;
  localparam logic [2:0] LAG_R_SP = 3'h4;
  localparam logic [2:0] LAG_R_BP = 3'h5;
  localparam logic [2:0] LAG_R_SI = 3'h6;
  localparam logic [2:0] LAG_R_DI = 3'h7;
  localparam int LAG_NUM_GPR = 8;
  localparam int LAG_BYTE_REGS = 4;
  // Register byte offsets
  localparam logic [7:0] LAG_CTRL = 8'h00;
  localparam logic [7:0] LAG_OPER = 8'h04;
  localparam logic [7:0] LAG_DISP_LO = 8'h08;
  localparam logic [7:0] LAG_DISP_HI = 8'h0c;
  localparam logic [7:0] LAG_BASE_UP = 8'h10;
  localparam logic [7:0] LAG_INDEX_UP = 8'h14;
  localparam logic [7:0] LAG_SEG_IDX = 8'h18;
  localparam logic [7:0] LAG_SEG_LO = 8'h1c;
  localparam logic [7:0] LAG_SEG_HI = 8'h20;
  localparam logic [7:0] LAG_GPR_SEL = 8'h24;
  localparam logic [7:0] LAG_GPR_DATA = 8'h28;
  localparam logic [7:0] LAG_CMD = 8'h2c;
  localparam logic [7:0] LAG_IPNEW_LO = 8'h30;
  localparam logic [7:0] LAG_IPNEW_HI = 8'h34;
  localparam logic [7:0] LAG_IP_LO = 8'h38;
  localparam logic [7:0] LAG_IP_HI = 8'h3c;
  localparam logic [7:0] LAG_EA_LO = 8'h40;
  localparam logic [7:0] LAG_EA_HI = 8'h44;
  localparam logic [7:0] LAG_LA_LO = 8'h48;
  localparam logic [7:0] LAG_LA_HI = 8'h4c;
  localparam logic [7:0] LAG_RESULT = 8'h50;
  localparam logic [7:0] LAG_STATUS = 8'h54;
  localparam logic [7:0] LAG_MASK = 8'h58;
  localparam logic [7:0] LAG_STRING = 8'h5c;
  // Status / mask bit positions
  localparam int LAG_ST_DONE = 0;
  localparam int LAG_ST_GP = 1;
  localparam int LAG_ST_SF = 2;
  localparam int LAG_ST_W = 3;
  localparam int LAG_PHYS_BITS = 36;
  localparam logic [63:0] LAG_IP_RESET = 64'h0;
endpackage : lag_pkg

// >>> core/lag_addr_gen.sv
// Purpose: Effective/linear address generation with canonical check, on AHB-Lite.
// Assumes: Single clock, synchronous active-low reset, single word transfers.
// Notes: Writes take no wait state, reads take one so read data is never stale.
`timescale 1ns/1ps
module lag_addr_gen
  import lag_pkg::*;
#(
  parameter int LIN_WIDTH = 48
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  output logic gpFault,
  output logic stackFault,
  output logic extPhysAvail
);
  // Control fields
  lag_mode_t mode;
  logic defAddr32;
  logic addrOverride;
  logic protMode;
  logic extPhysEn;
  // Operand fields
  logic [2:0] baseSel;
  logic baseEn;
  logic [2:0] indexSel;
  logic indexEn;
  logic [1:0] scale;
  logic disp64;
  lag_seg_t segOvr;
  logic segOvrEn;
  logic pushPop;
  logic [1:0] strKind;
  logic [31:0] dispLo;
  logic [31:0] dispHi;
  logic [31:0] baseUp;
  logic [31:0] indexUp;
  logic [2:0] segIdx;
  logic [63:0] segBase [6];
  logic [2:0] gprSel;
  lag_view_t gprView;
  logic [63:0] ipNew;
  logic [63:0] ip;
  logic [63:0] eaOut;
  logic [63:0] laOut;
  logic [5:0] result;
  logic [LAG_ST_W-1:0] status;
  logic [LAG_ST_W-1:0] mask;
  // Bus pipeline
  logic wrPend;
  logic rdPend;
  logic [7:0] busAddr;
  logic [31:0] gprA;
  logic [31:0] gprB;
  logic [31:0] aliasData;
  logic [31:0] strCount;
  logic [31:0] strSrc;
  logic [31:0] strDst;

  wire addrPhase = hsel && htrans[1] && hready;
  wire wrHit = wrPend;
  wire [31:0] wd = hwdata;
  wire goCalc = wrHit && busAddr == LAG_CMD && wd[0];
  wire goIp = wrHit && busAddr == LAG_CMD && wd[1];
  wire gprWr = wrHit && busAddr == LAG_GPR_DATA;

  lag_gpr_file u_gpr (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(gprWr),
    .wrSel(gprSel),
    .wrView(gprView),
    .wrData(wd),
    .rdSelA(strKind == 2'h1 ? LAG_R_SI : strKind == 2'h2 ? LAG_R_DI : baseSel),
    .rdDataA(gprA),
    .rdSelB(indexSel),
    .rdDataB(gprB),
    .aliasSel(gprSel),
    .aliasView(gprView),
    .aliasData(aliasData),
    .strCount(strCount),
    .strSrc(strSrc),
    .strDst(strDst)
  );

  function automatic logic [63:0] truncTo(input logic [63:0] v, input lag_asz_t sz);
    unique case (sz)
      LAG_ASZ_16: return {48'h0, v[15:0]};
      LAG_ASZ_32: return {32'h0, v[31:0]};
      default: return v;
    endcase
  endfunction : truncTo

  // Bits 63 down to the top implemented bit must all agree
  function automatic logic isCanonical(input logic [63:0] a);
    logic [63:0] upper;
    upper = a >> (LIN_WIDTH - 1);
    return upper == 64'h0 || upper == (64'hffff_ffff_ffff_ffff >> (LIN_WIDTH - 1));
  endfunction : isCanonical

  // Address size after any override
  lag_asz_t asz;
  always_comb begin
    if (mode == LAG_MODE_64) begin
      asz = addrOverride ? LAG_ASZ_32 : LAG_ASZ_64;
    end else begin
      asz = (defAddr32 ^ addrOverride) ? LAG_ASZ_32 : LAG_ASZ_16;
    end
  end

  // Operand formation
  logic [63:0] baseVal;
  logic [63:0] indexVal;
  logic [63:0] dispVal;
  logic [63:0] eaSum;
  logic [63:0] eaNext;
  logic baseUsed;
  always_comb begin
    baseUsed = baseEn || strKind != 2'h0;
    baseVal = 64'h0;
    indexVal = 64'h0;
    if (baseUsed) begin
      baseVal = (asz == LAG_ASZ_64) ? {baseUp, gprA} : {32'h0, gprA};
    end
    if (indexEn && strKind == 2'h0) begin
      indexVal = (asz == LAG_ASZ_64) ? {indexUp, gprB} : {32'h0, gprB};
    end
    // Only the register-move form carries a full 64-bit displacement
    dispVal = disp64 ? {dispHi, dispLo} : {{32{dispLo[31]}}, dispLo};
    eaSum = baseVal + (indexVal << scale) + dispVal;
    eaNext = truncTo(eaSum, asz);
  end

  // Segment selection
  lag_seg_t segDef;
  lag_seg_t segEff;
  logic stackBase;
  always_comb begin
    stackBase = baseEn && strKind == 2'h0 && (baseSel == LAG_R_SP || baseSel == LAG_R_BP);
    if (strKind == 2'h2) begin
      segDef = LAG_SEG_EXTRA;
    end else if (stackBase || pushPop) begin
      segDef = LAG_SEG_STACK;
    end else begin
      segDef = LAG_SEG_DATA;
    end
    segEff = segDef;
    if (segOvrEn && strKind != 2'h2) begin
      if (mode != LAG_MODE_64) begin
        segEff = segOvr;
      end else if (segOvr == LAG_SEG_XF || segOvr == LAG_SEG_XG) begin
        segEff = segOvr;
      end
    end
  end

  // Linear address and fault
  logic [63:0] laNext;
  logic canonNext;
  logic gpNext;
  logic sfNext;
  always_comb begin
    if (mode == LAG_MODE_64) begin
      if (segEff == LAG_SEG_XF || segEff == LAG_SEG_XG) begin
        laNext = eaNext + segBase[segEff];
      end else begin
        laNext = eaNext;
      end
    end else begin
      // Legacy linear space is 4 GBytes
      laNext = truncTo(eaNext + {32'h0, segBase[segEff][31:0]}, LAG_ASZ_32);
    end
    canonNext = mode != LAG_MODE_64 || isCanonical(laNext);
    gpNext = !canonNext && segEff != LAG_SEG_STACK;
    sfNext = !canonNext && segEff == LAG_SEG_STACK;
  end

  // AHB data-phase tracking
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      busAddr <= 8'h0;
    end else begin
      rdPend <= addrPhase && !hwrite;
      if (hready) begin
        wrPend <= addrPhase && hwrite;
      end
      if (addrPhase) begin
        busAddr <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Reads are answered after one wait state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !(addrPhase && !hwrite);
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
    end else if (rdPend) begin
      unique case (busAddr)
        LAG_CTRL: hrdata <= {26'h0, extPhysEn, protMode, addrOverride, defAddr32, mode};
        LAG_OPER: hrdata <= {14'h0, strKind, pushPop, segOvrEn, segOvr, disp64, scale,
                             indexEn, indexSel, baseEn, baseSel};
        LAG_DISP_LO: hrdata <= dispLo;
        LAG_DISP_HI: hrdata <= dispHi;
        LAG_BASE_UP: hrdata <= baseUp;
        LAG_INDEX_UP: hrdata <= indexUp;
        LAG_SEG_IDX: hrdata <= {29'h0, segIdx};
        LAG_SEG_LO: hrdata <= segIdx < 3'h6 ? segBase[segIdx][31:0] : 32'h0;
        LAG_SEG_HI: hrdata <= segIdx < 3'h6 ? segBase[segIdx][63:32] : 32'h0;
        LAG_GPR_SEL: hrdata <= {27'h0, gprView, gprSel};
        LAG_GPR_DATA: hrdata <= aliasData;
        LAG_IPNEW_LO: hrdata <= ipNew[31:0];
        LAG_IPNEW_HI: hrdata <= ipNew[63:32];
        LAG_IP_LO: hrdata <= ip[31:0];
        LAG_IP_HI: hrdata <= ip[63:32];
        LAG_EA_LO: hrdata <= eaOut[31:0];
        LAG_EA_HI: hrdata <= eaOut[63:32];
        LAG_LA_LO: hrdata <= laOut[31:0];
        LAG_LA_HI: hrdata <= laOut[63:32];
        LAG_RESULT: hrdata <= {25'h0, extPhysAvail, result};
        LAG_STATUS: hrdata <= {29'h0, status};
        LAG_MASK: hrdata <= {29'h0, mask};
        LAG_STRING: hrdata <= strCount;
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= LAG_MODE_LEGACY;
      defAddr32 <= 1'b1;
      addrOverride <= 1'b0;
      protMode <= 1'b0;
      extPhysEn <= 1'b0;
      {baseSel, baseEn, indexSel, indexEn, scale, disp64} <= 11'h0;
      segOvr <= LAG_SEG_EXTRA;
      segOvrEn <= 1'b0;
      pushPop <= 1'b0;
      strKind <= 2'h0;
      dispLo <= 32'h0;
      dispHi <= 32'h0;
      baseUp <= 32'h0;
      indexUp <= 32'h0;
      segIdx <= 3'h0;
      gprSel <= 3'h0;
      gprView <= LAG_VIEW_DWORD;
      ipNew <= 64'h0;
      mask <= '0;
    end else if (wrHit) begin
      unique case (busAddr)
        LAG_CTRL: begin
          mode <= lag_mode_t'(wd[1:0] == 2'h3 ? 2'h0 : wd[1:0]);
          defAddr32 <= wd[2];
          addrOverride <= wd[3];
          protMode <= wd[4];
          extPhysEn <= wd[5];
        end
        LAG_OPER: begin
          baseSel <= wd[2:0];
          baseEn <= wd[3];
          indexSel <= wd[6:4];
          indexEn <= wd[7];
          scale <= wd[9:8];
          disp64 <= wd[10];
          segOvr <= lag_seg_t'(wd[13:11] > 3'h5 ? 3'h3 : wd[13:11]);
          segOvrEn <= wd[14];
          pushPop <= wd[15];
          strKind <= wd[17:16] == 2'h3 ? 2'h0 : wd[17:16];
        end
        LAG_DISP_LO: dispLo <= wd;
        LAG_DISP_HI: dispHi <= wd;
        LAG_BASE_UP: baseUp <= wd;
        LAG_INDEX_UP: indexUp <= wd;
        LAG_SEG_IDX: segIdx <= wd[2:0];
        LAG_GPR_SEL: begin
          gprSel <= wd[2:0];
          gprView <= lag_view_t'(wd[4:3]);
        end
        LAG_IPNEW_LO: ipNew[31:0] <= wd;
        LAG_IPNEW_HI: ipNew[63:32] <= wd;
        LAG_MASK: mask <= wd[LAG_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Segment base table
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) segBase[i] <= 64'h0;
    end else if (wrHit && segIdx < 3'h6) begin
      if (busAddr == LAG_SEG_LO) segBase[segIdx][31:0] <= wd;
      if (busAddr == LAG_SEG_HI) segBase[segIdx][63:32] <= wd;
    end
  end

  // Instruction pointer update by size
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ip <= LAG_IP_RESET;
    end else if (goIp) begin
      unique case (lag_asz_t'(wd[3:2]))
        LAG_ASZ_16: ip[15:0] <= ipNew[15:0];
        LAG_ASZ_32: ip <= {32'h0, ipNew[31:0]};
        default: ip <= ipNew;
      endcase
    end
  end

  // Address calculation results
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eaOut <= 64'h0;
      laOut <= 64'h0;
      result <= 6'h0;
      gpFault <= 1'b0;
      stackFault <= 1'b0;
    end else if (goCalc) begin
      eaOut <= eaNext;
      laOut <= laNext;
      result <= {segEff, canonNext, sfNext, gpNext};
      gpFault <= gpNext;
      stackFault <= sfNext;
    end
  end

  // Paging beyond 4 GBytes needs protected mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extPhysAvail <= 1'b0;
    end else begin
      extPhysAvail <= protMode && extPhysEn && mode == LAG_MODE_LEGACY;
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  logic [LAG_ST_W-1:0] evt;
  logic [LAG_ST_W-1:0] clr;
  always_comb begin
    evt = '0;
    evt[LAG_ST_DONE] = goCalc;
    evt[LAG_ST_GP] = goCalc && gpNext;
    evt[LAG_ST_SF] = goCalc && sfNext;
    clr = (wrHit && busAddr == LAG_STATUS) ? wd[LAG_ST_W-1:0] : '0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= (status & ~clr) | evt;
      irq <= |(((status & ~clr) | evt) & mask);
    end
  end
endmodule : lag_addr_gen

// >>> core/lag_gpr_file.sv
// Purpose: Eight general registers with word and byte aliases.
// Assumes: One write port, combinational reads.
// Notes: High-byte view exists only for the first four registers.
`timescale 1ns/1ps
module lag_gpr_file
  import lag_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [2:0] wrSel,
  input wire lag_view_t wrView,
  input wire logic [31:0] wrData,
  input wire logic [2:0] rdSelA,
  output logic [31:0] rdDataA,
  input wire logic [2:0] rdSelB,
  output logic [31:0] rdDataB,
  input wire logic [2:0] aliasSel,
  input wire lag_view_t aliasView,
  output logic [31:0] aliasData,
  output logic [31:0] strCount,
  output logic [31:0] strSrc,
  output logic [31:0] strDst
);
  logic [31:0] gpr [LAG_NUM_GPR];

  function automatic logic hasHigh(input logic [2:0] sel);
    return 32'(sel) < LAG_BYTE_REGS;
  endfunction : hasHigh

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < LAG_NUM_GPR; i++) gpr[i] <= 32'h0;
    end else if (wrEn) begin
      unique case (wrView)
        LAG_VIEW_DWORD: gpr[wrSel] <= wrData;
        LAG_VIEW_WORD: gpr[wrSel][15:0] <= wrData[15:0];
        LAG_VIEW_LOW: if (hasHigh(wrSel)) gpr[wrSel][7:0] <= wrData[7:0];
        LAG_VIEW_HIGH: if (hasHigh(wrSel)) gpr[wrSel][15:8] <= wrData[7:0];
      endcase
    end
  end

  always_comb begin
    aliasData = 32'h0;
    unique case (aliasView)
      LAG_VIEW_DWORD: aliasData = gpr[aliasSel];
      LAG_VIEW_WORD: aliasData = {16'h0, gpr[aliasSel][15:0]};
      LAG_VIEW_LOW: if (hasHigh(aliasSel)) aliasData = {24'h0, gpr[aliasSel][7:0]};
      LAG_VIEW_HIGH: if (hasHigh(aliasSel)) aliasData = {24'h0, gpr[aliasSel][15:8]};
    endcase
  end

  assign rdDataA = gpr[rdSelA];
  assign rdDataB = gpr[rdSelB];
  // Implicit string operands
  assign strCount = gpr[LAG_R_CNT];
  assign strSrc = gpr[LAG_R_SI];
  assign strDst = gpr[LAG_R_DI];
endmodule : lag_gpr_file

// >>> testbench/lag_addr_gen_sva.sv
// Purpose: Port-level checks of bus timing and fault reporting.
// Assumes: hready is fed back from hreadyout; one clock domain.
// Notes: Internal status is not visible, so updates are tied to write data phases.
`timescale 1ns/1ps
module lag_addr_gen_chk
  import lag_pkg::*;
#(
  parameter int LIN_WIDTH = 48
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic irq,
  input wire logic gpFault,
  input wire logic stackFault,
  input wire logic extPhysAvail
);
  logic wrPhase;
  logic rdPhase;
  wire taken = hsel && htrans[1] && hready;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPhase <= 1'b0;
      rdPhase <= 1'b0;
    end else begin
      wrPhase <= taken && hwrite;
      rdPhase <= taken && !hwrite;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  write_nowait_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  single_wait_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(rdPhase))
    else $error("read data changed outside a read");
  fault_onehot_a: assert property (!(gpFault && stackFault))
    else $error("both fault kinds raised together");
  fault_update_a: assert property ($changed({gpFault, stackFault}) |-> $past(wrPhase))
    else $error("fault changed without a command write");
  ext_phys_a: assert property ($changed(extPhysAvail) |-> $past(wrPhase) || $past(wrPhase, 2))
    else $error("extended addressing flag changed without a write");
  irq_update_a: assert property ($changed(irq) |-> $past(wrPhase) || $past(wrPhase, 2))
    else $error("interrupt changed without a write");
  cover property (taken && !hwrite);
  cover property ($rose(gpFault));
  cover property ($rose(stackFault));
  cover property ($rose(irq));
endmodule : lag_addr_gen_chk

bind lag_addr_gen lag_addr_gen_chk #(.LIN_WIDTH(LIN_WIDTH)) chk_i (.clk(clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .gpFault(gpFault),
  .stackFault(stackFault), .extPhysAvail(extPhysAvail));

// >>> testbench/test_lag_addr_gen.sv
// Purpose: Register-level test of address generation, faults, pointer and aliases.
// Assumes: Single AHB-Lite master; hready taken from hreadyout.
// Notes: Result bit 2 is masked, its value outside 64-bit mode is left open.
`timescale 1ns/1ps
module test_lag_addr_gen;
  import lag_pkg::*;
  logic clk;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic irq;
  logic gpFault;
  logic stackFault;
  logic extPhysAvail;
  logic [31:0] v;
  wire hready = hreadyout;
  int err_total;
  int total_checks;
  int cycles;
  // ctrl, oper, base upper, EA hi, EA lo, LA lo, masked result
  localparam logic [15:0] ROWS [70] = '{
    16'h02, 16'h028b, 16'h7fff, 16'h7fff, 16'h1030, 16'h1030, 16'h18,
    16'h02, 16'h028b, 16'h8000, 16'h8000, 16'h1030, 16'h1030, 16'h19,
    16'h02, 16'h028c, 16'h8000, 16'h8000, 16'h1030, 16'h1030, 16'h12,
    16'h02, 16'h628c, 16'h8000, 16'h8000, 16'h1030, 16'h1130, 16'h21,
    16'h02, 16'h528b, 16'h8000, 16'h8000, 16'h1030, 16'h1030, 16'h19,
    16'h02, 16'h828b, 16'h8000, 16'h8000, 16'h1030, 16'h1030, 16'h12,
    16'h0a, 16'h028b, 16'h8000, 16'h0000, 16'h1030, 16'h1030, 16'h18,
    16'h00, 16'h028b, 16'h8000, 16'h0000, 16'h1030, 16'h2264, 16'h18,
    16'h05, 16'h028b, 16'h8000, 16'h0000, 16'h1030, 16'h2264, 16'h18,
    16'h02, 16'h068b, 16'h7fff, 16'h8000, 16'h1030, 16'h1030, 16'h19};

  lag_addr_gen #(.LIN_WIDTH(48)) lag_addr_gen_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .gpFault(gpFault),
    .stackFault(stackFault), .extPhysAvail(extPhysAvail));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // Hang guard, well above the roughly 150 transfers of the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rdchk

  task automatic gpr(input logic [4:0] sel, input logic [31:0] d);
    wr(LAG_GPR_SEL, {27'h0, sel});
    wr(LAG_GPR_DATA, d);
  endtask : gpr

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_total = 0;
    total_checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(LAG_CTRL, 32'h4);
    rdchk(LAG_IP_LO, 32'h0);
    rdchk(8'h60, 32'h0);
    wr(8'h60, 32'hffffffff);
    rdchk(LAG_CTRL, 32'h4);
    gpr({2'h0, LAG_R_BASE}, 32'h1000);
    gpr({2'h0, LAG_R_SP}, 32'h1000);
    gpr({2'h0, LAG_R_ACC}, 32'h10);
    wr(LAG_SEG_IDX, 32'h3);
    wr(LAG_SEG_LO, 32'h1234);
    wr(LAG_SEG_IDX, 32'h4);
    wr(LAG_SEG_LO, 32'h100);
    wr(LAG_DISP_LO, 32'hfffffff0);
    wr(LAG_DISP_HI, 32'h0);
    for (int i = 0; i < 10; i++) begin
      wr(LAG_CTRL, {16'h0, ROWS[i*7]});
      wr(LAG_BASE_UP, {16'h0, ROWS[i*7+2]});
      wr(LAG_OPER, {16'h0, ROWS[i*7+1]});
      wr(LAG_CMD, 32'h1);
      rdchk(LAG_EA_HI, {16'h0, ROWS[i*7+3]});
      rdchk(LAG_EA_LO, {16'h0, ROWS[i*7+4]});
      rdchk(LAG_LA_LO, {16'h0, ROWS[i*7+5]});
      xfer(1'b0, LAG_RESULT, 32'h0, v);
      chk(v & 32'h7b, {16'h0, ROWS[i*7+6]});
      chk({31'h0, gpFault}, {31'h0, ROWS[i*7+6][0]});
      chk({31'h0, stackFault}, {31'h0, ROWS[i*7+6][1]});
    end
    // String destination: index register base, extra segment, override ignored
    wr(LAG_SEG_IDX, 32'h0);
    wr(LAG_SEG_LO, 32'h5000);
    gpr({2'h0, LAG_R_DI}, 32'h200);
    wr(LAG_CTRL, 32'h4);
    wr(LAG_OPER, 32'h25800);
    wr(LAG_CMD, 32'h1);
    rdchk(LAG_EA_LO, 32'h1f0);
    rdchk(LAG_LA_LO, 32'h51f0);
    xfer(1'b0, LAG_RESULT, 32'h0, v);
    chk(v & 32'h7b, 32'h0);
    chk({31'h0, gpFault}, 32'h0);
    rdchk(LAG_STATUS, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wr(LAG_MASK, 32'h1);
    rdchk(LAG_STATUS, 32'h7);
    chk({31'h0, irq}, 32'h1);
    wr(LAG_STATUS, 32'h1);
    rdchk(LAG_STATUS, 32'h6);
    chk({31'h0, irq}, 32'h0);
    wr(LAG_IPNEW_LO, 32'h89abcdef);
    wr(LAG_IPNEW_HI, 32'h01234567);
    wr(LAG_CMD, 32'ha);
    rdchk(LAG_IP_HI, 32'h01234567);
    rdchk(LAG_IP_LO, 32'h89abcdef);
    wr(LAG_IPNEW_LO, 32'h33334444);
    wr(LAG_IPNEW_HI, 32'h11112222);
    wr(LAG_CMD, 32'h2);
    rdchk(LAG_IP_HI, 32'h01234567);
    rdchk(LAG_IP_LO, 32'h89ab4444);
    wr(LAG_CMD, 32'h6);
    rdchk(LAG_IP_HI, 32'h0);
    rdchk(LAG_IP_LO, 32'h33334444);
    gpr(5'h00, 32'h11223344);
    gpr(5'h08, 32'haaaa5566);
    gpr(5'h18, 32'h77);
    wr(LAG_GPR_SEL, 32'h00);
    rdchk(LAG_GPR_DATA, 32'h11227766);
    wr(LAG_GPR_SEL, 32'h18);
    rdchk(LAG_GPR_DATA, 32'h77);
    wr(LAG_GPR_SEL, 32'h10);
    rdchk(LAG_GPR_DATA, 32'h66);
    wr(LAG_GPR_SEL, 32'h08);
    rdchk(LAG_GPR_DATA, 32'h7766);
    gpr(5'h1c, 32'h99);
    rdchk(LAG_GPR_DATA, 32'h0);
    wr(LAG_GPR_SEL, {29'h0, LAG_R_SP});
    rdchk(LAG_GPR_DATA, 32'h1000);
    gpr({2'h0, LAG_R_CNT}, 32'h5);
    rdchk(LAG_STRING, 32'h5);
    wr(LAG_CTRL, 32'h30);
    rdchk(LAG_CTRL, 32'h30);
    chk({31'h0, extPhysAvail}, 32'h1);
    wr(LAG_CTRL, 32'h32);
    rdchk(LAG_CTRL, 32'h32);
    chk({31'h0, extPhysAvail}, 32'h0);
    finish_test();
  end
endmodule : test_lag_addr_gen
